// >>> common/csc_pkg.sv
// Constants, types and helper functions for the card-side SPI command framer.
// Assumes a single core clock at 200 MHz and a link clock that is only sampled.
//
// Functional notes
// - Time-out limit is ten times the typical access or program time.
// - Card finishes a command within time-out or abandons it and reports error.
// - Read access time is time field plus clock-count field, end bit to start bit.
// - Block program time is read access time times write speed multiplier.
// - Erase time is erased block count times block program time.
// - Read-ahead past last address raises address-beyond-end, shown at stop command; code shows and clears it at whichever command comes next.
// - Lock and unlock answer with response then busy; host reads status afterwards.
// - Application-command status flag is never provided in SPI mode.
// - Every command token is exactly six bytes and checksum protected.
// - Command tokens travel most significant bit first.
// - Token: start 0, transmission 1, index, argument, CRC7, end bit 1.
// - One command class field governs supported classes in both modes.
// - Basic, block-read and block-write classes accept their listed commands.
// - Erase, write-protect, lock and application classes accept their listed commands.
// - Classes 1, 3 and 9 unsupported in SPI; classes 10 and 11 reserved.
// - Command of unsupported class sets the illegal-command flag in the response.
package csc_pkg;

  // ----------------------------------------------------------------------
  // Token layout
  // ----------------------------------------------------------------------
  localparam int unsigned TOKEN_BITS = 48;
  localparam int unsigned START_POS = 47;
  localparam int unsigned TRANS_POS = 46;
  localparam int unsigned IDX_HI = 45;
  localparam int unsigned IDX_LO = 40;
  localparam int unsigned ARG_HI = 39;
  localparam int unsigned ARG_LO = 8;
  localparam int unsigned CRC_HI = 7;
  localparam int unsigned CRC_LO = 1;
  localparam int unsigned END_POS = 0;
  localparam int unsigned CRC_DATA_BITS = 40;
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [5:0] BIT_CNT_LAST = 6'h2F;

  // ----------------------------------------------------------------------
  // Response byte fields
  // ----------------------------------------------------------------------
  localparam int unsigned RESP_BITS = 8;
  localparam int unsigned R_IDLE = 0;
  localparam int unsigned R_ILLEGAL = 2;
  localparam int unsigned R_CRC = 3;
  localparam int unsigned R_ADDR = 5;
  localparam int unsigned R_PARAM = 6;
  localparam logic [3:0] GAP_BITS = 4'h8;

  // ----------------------------------------------------------------------
  // Command indices
  // ----------------------------------------------------------------------
  localparam logic [5:0] CMD_RESET = 6'h00;
  localparam logic [5:0] CMD_INIT = 6'h01;
  localparam logic [5:0] CMD_STOP = 6'h0C;
  localparam logic [5:0] CMD_LOCK = 6'h2A;
  localparam logic [5:0] CMD_APP = 6'h37;

  // ----------------------------------------------------------------------
  // Time-out scaling
  // ----------------------------------------------------------------------
  localparam int unsigned TIME_W = 24;
  localparam int unsigned LIMIT_W = 52;
  localparam logic [3:0] TIMEOUT_FACTOR = 4'hA;

  typedef enum logic [1:0] {CSC_OP_READ, CSC_OP_WRITE, CSC_OP_ERASE} csc_op_t;

  // Card-specific timing fields, already in core clock cycles
  typedef struct packed {
    logic [TIME_W-1:0] read_access_time_base;
    logic [TIME_W-1:0] read_access_clock_count;
    logic [5:0] write_speed_multiplier;
    logic [15:0] erase_blocks;
  } csc_timing_t;

  // Decoded command handed to the user side
  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
    logic app;
  } csc_cmd_t;

  // Class mask for a command index; bit n set means member of class n
  function automatic logic [11:0] csc_class_mask(input logic [5:0] idx);
    logic [11:0] m;
    m = 12'h000;
    case (idx)
      6'h00, 6'h01, 6'h09, 6'h0A, 6'h0D, 6'h3A, 6'h3B: m = 12'h001;
      6'h0C, 6'h11, 6'h12: m = 12'h004;
      6'h10, 6'h17: m = 12'h014;
      6'h18, 6'h19, 6'h1B: m = 12'h010;
      6'h23, 6'h24, 6'h26: m = 12'h020;
      6'h1C, 6'h1D, 6'h1E: m = 12'h040;
      6'h2A: m = 12'h080;
      6'h37, 6'h38: m = 12'h100;
      default: m = 12'h000;
    endcase
    return m;
  endfunction

  // Commands answered with response followed by busy
  function automatic logic csc_busy_cmd(input logic [5:0] idx);
    return (idx == 6'h18) || (idx == 6'h19) || (idx == 6'h1B) || (idx == 6'h1C) ||
           (idx == 6'h1D) || (idx == 6'h26) || (idx == 6'h2A);
  endfunction

endpackage

// >>> tb/csc_chk.sv
// Checker on the framer's ports.
// Assumes timing fields are already in core clock cycles.
`timescale 1ns/10ps
`default_nettype none
module csc_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Watched signals
  input wire logic cs_n_i,
  input wire logic [11:0] command_class_field_i,
  input wire csc_pkg::csc_timing_t timing_i,
  input wire logic cmd_valid_o,
  input wire csc_pkg::csc_cmd_t cmd_o,
  input wire logic op_busy_i,
  input wire csc_pkg::csc_op_t op_kind_i,
  input wire logic op_abort_o,
  input wire logic timeout_err_o
);
  import csc_pkg::*;
  logic [63:0] lim, cnt_q, cnt_d;
  always_comb begin
    lim = (64'(timing_i.read_access_time_base) + 64'(timing_i.read_access_clock_count)) * 64'hA;
    if (op_kind_i == CSC_OP_WRITE) lim = lim * 64'(timing_i.write_speed_multiplier);
    if (op_kind_i == CSC_OP_ERASE) lim = lim * 64'(timing_i.write_speed_multiplier) * 64'(timing_i.erase_blocks);
    cnt_d = op_busy_i ? cnt_q + 64'h1 : 64'h0;
  end
  always_ff @(posedge clk_i) cnt_q <= resetn_i ? cnt_d : 64'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_abort_late; op_abort_o |-> cnt_q + 64'h2 >= lim; endproperty
  a_abort_late: assert property (p_abort_late) else $error("abort before limit");
  property p_abort_due; op_busy_i && cnt_q == lim && !timeout_err_o |=> op_abort_o && timeout_err_o; endproperty
  a_abort_due: assert property (p_abort_due) else $error("no time-out at limit");
  property p_abort_once; op_abort_o |=> !op_abort_o [*8]; endproperty
  a_abort_once: assert property (p_abort_once) else $error("abort repeated");
  property p_err_set; op_abort_o |=> timeout_err_o; endproperty
  a_err_set: assert property (p_err_set) else $error("error flag missing");
  property p_valid_pulse; cmd_valid_o |=> !cmd_valid_o; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_valid_cs; cmd_valid_o |-> !$past(cs_n_i, 8); endproperty
  a_valid_cs: assert property (p_valid_cs) else $error("valid while deselected");
  property p_valid_legal;
    cmd_valid_o |-> !(cmd_o.index inside {[2:8], 11, 14, 15, [19:22], 26, [31:34], 37, [39:41], [43:54], 57, [60:63]});
  endproperty
  a_valid_legal: assert property (p_valid_legal) else $error("illegal index accepted");
  property p_lock_gate; cmd_valid_o && cmd_o.index == CMD_LOCK |-> command_class_field_i[7]; endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("lock class off");
  property p_read_gate; cmd_valid_o && cmd_o.index == 6'h11 |-> command_class_field_i[2]; endproperty
  a_read_gate: assert property (p_read_gate) else $error("read class off");
  c_abort: cover property (op_abort_o);
  c_app: cover property (cmd_valid_o && cmd_o.app);
  c_lock: cover property (cmd_valid_o && cmd_o.index == CMD_LOCK);
endmodule // csc_chk
bind csc_cmd_framer csc_chk csc_chk_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
  .command_class_field_i(command_class_field_i), .timing_i(timing_i), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
  .op_busy_i(op_busy_i), .op_kind_i(op_kind_i), .op_abort_o(op_abort_o), .timeout_err_o(timeout_err_o));
`default_nettype wire

// >>> tb/csc_host_model.sv
// Host controller model: shifts command tokens out and collects the answer.
// Assumes the card answers within 24 link clocks of the token end.
`timescale 1ns/10ps
`default_nettype none
module csc_host_model (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  task automatic tick(output logic s);
    #80 sclk_o = 1'b1;
    s = miso_i;
    #80 sclk_o = 1'b0;
  endtask
  task automatic xfer(input logic [47:0] t, output logic [7:0] r, output int b);
    logic s;
    int n;
    cs_n_o = 1'b0;
    for (int i = 47; i >= 0; i--) begin
      mosi_o = t[i];
      tick(s);
    end
    mosi_o = 1'b1;
    n = 0;
    s = 1'b1;
    while (s !== 1'b0 && n < 24) begin
      tick(s);
      n++;
    end
    r[7] = s;
    for (int i = 6; i >= 0; i--) tick(r[i]);
    b = 0;
    s = 1'b0;
    while (s !== 1'b1 && b < 400) begin
      tick(s);
      b++;
    end
    cs_n_o = 1'b1;
    repeat (8) tick(s);
  endtask
endmodule // csc_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Bench for the card-side command framer: one task per scenario.
// Assumes the host model paces the link at 160 ns per bit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import csc_pkg::*;
  logic clk_i = 0, resetn_i = 0, crc_check_en_i = 0, init_done_i = 0, op_busy_i = 0, prefetch_oor_i = 0;
  logic sclk, cs_n, mosi, miso_o, miso_oe_o, cmd_valid_o, op_abort_o, timeout_err_o;
  logic [11:0] command_class_field_i = 12'h001;
  csc_timing_t timing_i = '{24'h4, 24'h2, 6'h2, 16'h3};
  csc_op_t op_kind_i = CSC_OP_READ;
  csc_cmd_t cmd_o;
  int n_errors = 0, n_checks = 0;
  csc_cmd_framer csc_cmd_framer_inst (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .command_class_field_i(command_class_field_i),
    .crc_check_en_i(crc_check_en_i), .init_done_i(init_done_i), .timing_i(timing_i), .cmd_valid_o(cmd_valid_o),
    .cmd_o(cmd_o), .op_busy_i(op_busy_i), .op_kind_i(op_kind_i), .prefetch_oor_i(prefetch_oor_i),
    .op_abort_o(op_abort_o), .timeout_err_o(timeout_err_o));
  csc_host_model csc_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [5:0] idx, input logic bad, output logic [7:0] r, output int b);
    logic [39:0] d;
    logic [6:0] c;
    d = {2'b01, idx, 32'h0000_0000};
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    csc_host_model_inst.xfer({d, c ^ {6'h00, bad}, 1'b1}, r, b);
    if (b >= 400 || r[7] !== 1'b0) begin
      check("link_limit", 32'(b), 32'h0);
      give_verdict();
    end
  endtask
  task automatic ex(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    int b;
    cmd(idx, 1'b0, r, b);
    check("response", 32'(r), 32'(exp));
  endtask
  task automatic t_basic;
    ex(CMD_RESET, 8'h01);
    init_done_i = 1'b1;
    ex(CMD_INIT, 8'h01);
    ex(6'h09, 8'h00);
    check("index", 32'(cmd_o.index), 32'h09);
    ex(6'h0D, 8'h00);
    ex(6'h3A, 8'h00);
    ex(6'h3B, 8'h00);
    $display("t_basic done");
  endtask
  task automatic t_class;
    logic [5:0] bad[5] = '{6'h11, 6'h18, 6'h2A, 6'h06, 6'h14};
    logic [5:0] good[10] = '{6'h0C, 6'h11, 6'h17, 6'h18, 6'h1B, 6'h1C, 6'h1E, 6'h23, 6'h26, 6'h2A};
    foreach (bad[i]) ex(bad[i], 8'h04);
    cyc(1);
    command_class_field_i = 12'h1F5;
    foreach (good[i]) ex(good[i], 8'h00);
    $display("t_class done");
  endtask
  task automatic t_crc;
    logic [7:0] r;
    int b;
    cyc(1);
    crc_check_en_i = 1'b1;
    cmd(6'h0D, 1'b1, r, b);
    check("crc_resp", 32'(r), 32'h08);
    ex(6'h0D, 8'h00);
    $display("t_crc done");
  endtask
  task automatic t_timeout;
    int lim[3] = '{60, 120, 360};
    int n;
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      op_kind_i = csc_op_t'(k);
      op_busy_i = 1'b1;
      for (n = 0; n < 500 && op_abort_o !== 1'b1; n++) cyc(1);
      check("abort_cycle", 32'(n >= lim[k] - 1 && n <= lim[k] + 3), 32'h1);
      if (n >= 500) give_verdict();
      op_busy_i = 1'b0;
      cyc(2);
      check("timeout_err", 32'(timeout_err_o), 32'h1);
      ex(6'h0D, 8'h40);
      check("timeout_clr", 32'(timeout_err_o), 32'h0);
    end
    $display("t_timeout done");
  endtask
  task automatic t_prefetch;
    ex(6'h12, 8'h00);
    cyc(1);
    prefetch_oor_i = 1'b1;
    cyc(1);
    prefetch_oor_i = 1'b0;
    ex(CMD_STOP, 8'h20);
    ex(6'h0D, 8'h00);
    $display("t_prefetch done");
  endtask
  task automatic t_lock_app;
    logic [7:0] r;
    int b;
    int i;
    op_kind_i = CSC_OP_ERASE;
    timing_i.erase_blocks = 16'hFFFF;
    fork
      cmd(CMD_LOCK, 1'b0, r, b);
      begin
        for (i = 0; i < 4000 && cmd_valid_o !== 1'b1; i++) cyc(1);
        if (i >= 4000) begin
          check("valid_limit", 32'(i), 32'h0);
          give_verdict();
        end
        check("oe_sel", 32'(miso_oe_o), 32'h1);
        check("lock_index", 32'(cmd_o.index), 32'(CMD_LOCK));
        op_busy_i = 1'b1;
        cyc(1200);
        op_busy_i = 1'b0;
      end
    join
    check("lock_resp", 32'(r), 32'h00);
    check("lock_busy", 32'(b > 2), 32'h1);
    ex(CMD_APP, 8'h00);
    ex(6'h38, 8'h00);
    check("app", 32'(cmd_o.app), 32'h1);
    $display("t_lock_app done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    check("oe_reset", 32'(miso_oe_o), 32'h0);
    check("miso_reset", 32'(miso_o), 32'h1);
    check("valid_reset", 32'(cmd_valid_o), 32'h0);
    check("err_reset", 32'(timeout_err_o), 32'h0);
    resetn_i = 1'b1;
    cyc(8);
    t_basic();
    t_class();
    t_crc();
    t_timeout();
    t_prefetch();
    t_lock_app();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire

// >>> verilog/csc_cmd_framer.sv
// Card-side SPI command framer: receives tokens, checks them, answers and guards time-outs.
// Assumes link pins come from the host asynchronously; array logic sits on clk_i.
`timescale 1ns/10ps
`default_nettype none
module csc_cmd_framer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Configuration
  input wire logic [11:0] command_class_field_i,
  input wire logic crc_check_en_i,
  input wire logic init_done_i,
  input wire csc_pkg::csc_timing_t timing_i,
  // Array side
  output logic cmd_valid_o,
  output csc_pkg::csc_cmd_t cmd_o,
  input wire logic op_busy_i,
  input wire csc_pkg::csc_op_t op_kind_i,
  input wire logic prefetch_oor_i,
  output logic op_abort_o,
  output logic timeout_err_o
);
  import csc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum {ST_RECV, ST_GAP, ST_RESP, ST_BUSY} csc_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] pin;
    csc_state_t st;
    logic [47:0] sh;
    logic [5:0] cnt;
    logic [3:0] gap;
    logic [7:0] resp;
    logic busy_after;
    logic idle;
    logic app_next;
    logic oor;
    logic tmo;
    logic [LIMIT_W-1:0] tcnt;
    logic abort;
    logic cvalid;
    csc_cmd_t cmd;
    logic miso;
  } csc_reg_t;

  csc_reg_t q, d;

  logic sclk_rise, sclk_fall, cs_n, mosi;
  logic [6:0] crc;
  logic [TIME_W:0] read_t;
  logic [TIME_W+6:0] write_t;
  logic [LIMIT_W-1:0] typ, limit;
  logic [47:0] tok;
  logic frame_ok, crc_ok, legal;

  // ----------------------------------------------------------------------
  // Time-out limit
  // ----------------------------------------------------------------------
  always_comb begin
    read_t = {1'b0, timing_i.read_access_time_base} + {1'b0, timing_i.read_access_clock_count};
    write_t = (TIME_W+7)'(read_t) * (TIME_W+7)'(timing_i.write_speed_multiplier);
    case (op_kind_i)
      CSC_OP_READ: typ = LIMIT_W'(read_t);
      CSC_OP_WRITE: typ = LIMIT_W'(write_t);
      CSC_OP_ERASE: typ = LIMIT_W'(write_t) * LIMIT_W'(timing_i.erase_blocks);
      default: typ = LIMIT_W'(write_t);
    endcase
    limit = typ * LIMIT_W'(TIMEOUT_FACTOR);
  end

  // ----------------------------------------------------------------------
  // Token check
  // ----------------------------------------------------------------------
  always_comb begin
    tok = {q.sh[46:0], mosi};
    crc = 7'h00;
    for (int i = 0; i < CRC_DATA_BITS; i++) begin
      if (crc[6] ^ tok[START_POS-i]) begin
        crc = {crc[5:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc = {crc[5:0], 1'b0};
      end
    end
    crc_ok = !crc_check_en_i || (crc == tok[CRC_HI:CRC_LO]);
    frame_ok = !tok[START_POS] && tok[TRANS_POS] && tok[END_POS];
    legal = |(csc_class_mask(tok[IDX_HI:IDX_LO]) & command_class_field_i);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = {sclk_i, cs_n_i, mosi_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pin[i] = q.s2[i];
      end
    end
    sclk_rise = d.pin[2] && !q.pin[2];
    sclk_fall = !d.pin[2] && q.pin[2];
    cs_n = d.pin[1];
    mosi = d.pin[0];
    d.cvalid = 1'b0;
    d.abort = 1'b0;
    if (prefetch_oor_i) begin
      d.oor = 1'b1;
    end

    // Operation time-out guard
    if (op_busy_i && !q.tmo) begin
      d.tcnt = q.tcnt + 1'b1;
      if (q.tcnt >= limit) begin
        d.tmo = 1'b1;
        d.abort = 1'b1;
      end
    end else if (!op_busy_i) begin
      d.tcnt = '0;
    end

    case (q.st)
      ST_RECV: begin
        if (cs_n) begin
          d.cnt = '0;
        end else if (sclk_rise) begin
          d.sh = tok;
          if (q.cnt != 6'h00 || !mosi) begin
            d.cnt = q.cnt + 1'b1;
          end
          if (q.cnt == BIT_CNT_LAST) begin
            d.cnt = '0;
            d.resp = '0;
            d.resp[R_IDLE] = q.idle;
            d.resp[R_ADDR] = q.oor;
            d.resp[R_PARAM] = q.tmo;
            d.resp[R_CRC] = !crc_ok || !frame_ok;
            d.resp[R_ILLEGAL] = !legal;
            d.oor = prefetch_oor_i;
            // A time-out raised in this very cycle survives the clear
            d.tmo = d.tmo && !q.tmo;
            d.gap = '0;
            d.st = ST_GAP;
            d.busy_after = 1'b0;
            if (crc_ok && frame_ok && legal) begin
              d.cvalid = 1'b1;
              d.cmd.index = tok[IDX_HI:IDX_LO];
              d.cmd.arg = tok[ARG_HI:ARG_LO];
              d.cmd.app = q.app_next;
              d.app_next = (tok[IDX_HI:IDX_LO] == CMD_APP);
              d.busy_after = csc_busy_cmd(tok[IDX_HI:IDX_LO]);
              if (tok[IDX_HI:IDX_LO] == CMD_RESET) begin
                d.idle = 1'b1;
              end else if (tok[IDX_HI:IDX_LO] == CMD_INIT && init_done_i) begin
                d.idle = 1'b0;
              end
              if (tok[IDX_HI:IDX_LO] == CMD_STOP) begin
                d.resp[R_ADDR] = q.oor || prefetch_oor_i;
              end
            end else begin
              d.app_next = 1'b0;
            end
          end
        end
      end
      ST_GAP: begin
        if (sclk_fall) begin
          d.gap = q.gap + 1'b1;
          if (q.gap == GAP_BITS - 4'h1) begin
            d.miso = q.resp[7];
            d.resp = {q.resp[6:0], 1'b1};
            d.cnt = 6'h01;
            d.st = ST_RESP;
          end
        end
      end
      ST_RESP: begin
        if (sclk_fall) begin
          if (q.cnt == 6'(RESP_BITS)) begin
            d.cnt = '0;
            d.miso = !q.busy_after;
            d.st = q.busy_after ? ST_BUSY : ST_RECV;
          end else begin
            d.miso = q.resp[7];
            d.resp = {q.resp[6:0], 1'b1};
            d.cnt = q.cnt + 1'b1;
          end
        end
      end
      ST_BUSY: begin
        if (!op_busy_i && sclk_fall) begin
          d.miso = 1'b1;
          d.st = ST_RECV;
        end
      end
      default: d.st = ST_RECV;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.s1 <= 3'h2;
      q.s2 <= 3'h2;
      q.s3 <= 3'h2;
      q.pin <= 3'h2;
      q.st <= ST_RECV;
      q.idle <= 1'b1;
      q.miso <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign miso_o = q.miso;
  assign miso_oe_o = !q.pin[1];
  assign cmd_valid_o = q.cvalid;
  assign cmd_o = q.cmd;
  assign op_abort_o = q.abort;
  assign timeout_err_o = q.tmo;

endmodule // csc_cmd_framer
`default_nettype wire
